/* rtl/arop_pkg.sv */
// Constants and types for the converter result output port
// Overview of operation
// - Results leave the shift register most significant bit first.
// - Output coding select picks straight binary or two's complement.
// - Master serial: output bit stays stable across both serial clock edges.
// - Slave serial: bit changes on chosen edge, valid at the opposite edge.
// - Pins 9 to 11 are data in parallel, clock/frame/flag in serial.
// - Serial clock pin is driven by us internally, else by host.
// - Frame marker is driven only in serial mode with internal clock.
// - Frame marker active high, or low when frame polarity select is high.
// - Incomplete-read flag only in serial external-clock mode.
// - Slave read unfinished at next conversion end: drop it, pulse flag.
// - Upper four data bits are always outputs.
// - Busy rises at conversion start, falls once result is latched.
// - Outputs enabled only while chip select and read enable both low.
// - Clock source low drives internal clock; high follows external clock.
// - External clock edges ignored while chip select is inactive.
// - Falling edge on conversion start holds sample, begins conversion.
// - High reset input aborts any conversion in progress.
package arop_pkg;
   localparam int CLK_PERIOD_PS = 5000;
   localparam int CONV_TIME_NS = 700;
   localparam int CONV_CYC = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
      / CLK_PERIOD_PS;
   localparam int SCLK_QTR_NS = 10;
   localparam int QTR_CYC = (SCLK_QTR_NS * 1000 + CLK_PERIOD_PS - 1)
      / CLK_PERIOD_PS;
   localparam int WORD_W = 16;
   localparam int CONV_CNT_W = 8;
   localparam int QTR_W = 3;
   localparam logic [3:0] LAST_BIT = 4'hF;
   localparam logic [1:0] FIFO_DEPTH = 2'h2;
   localparam logic [CONV_CNT_W-1:0] CONV_LOAD = CONV_CNT_W'(CONV_CYC - 1);
   localparam logic [QTR_W-1:0] QTR_LOAD = QTR_W'(QTR_CYC - 1);
   localparam int PIN_SDO = 8;
   localparam int PIN_SCLK = 9;
   localparam int PIN_SYNC = 10;
   localparam int PIN_FLAG = 11;
   localparam int UPPER_LO = 12;
   localparam logic [1:0] PH_RISE = 2'h0;
   localparam logic [1:0] PH_FALL = 2'h2;
   localparam logic [1:0] PH_SHIFT = 2'h3;

   typedef enum logic [1:0] {
      AROP_IDLE = 2'b00,
      AROP_MASTER = 2'b01,
      AROP_SLAVE = 2'b10
   } arop_rd_type;

   typedef struct packed {
      logic ser;
      logic ext;
      logic inv;
      logic fpol;
      logic ob;
   } arop_cfg_type;

   typedef struct packed {
      logic [WORD_W-1:0] dout;
      logic [WORD_W-1:0] oe;
   } arop_pins_type;
endpackage

/* rtl/arop_port.sv */
// Result output port: conversion sequencing, buffer, parallel/serial output
`timescale 1ns/1ps
`default_nettype none
module arop_port
   import arop_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic reset_pin,
   input wire logic conversion_start_n,
   input wire logic [WORD_W-1:0] sample_code,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic serial_parallel_select,
   input wire logic clock_source_select,
   input wire logic clock_invert_select,
   input wire logic frame_polarity_select,
   input wire logic output_coding_select,
   input wire logic sclk_pin_in,
   output logic busy,
   output logic [WORD_W-1:0] data_pin_out,
   output logic [WORD_W-1:0] data_pin_oe
);

   typedef struct packed {
      arop_cfg_type cfg1;
      arop_cfg_type cfg2;
      logic cnv1;
      logic cnv2;
      logic cnv3;
      logic cs1;
      logic cs2;
      logic rd1;
      logic rd2;
      logic rst1;
      logic rst2;
      logic sclk1;
      logic sclk2;
      logic sclk3;
      logic busy;
      logic [CONV_CNT_W-1:0] conv_cnt;
      logic [WORD_W-1:0] sample;
      logic [1:0][WORD_W-1:0] mem;
      logic wp;
      logic rp;
      logic [1:0] fcnt;
      logic [WORD_W-1:0] word;
      logic [WORD_W-1:0] shreg;
      logic [3:0] bits;
      logic [QTR_W-1:0] qtr;
      logic [1:0] phase;
      arop_rd_type state;
      logic sclk_int;
      logic flag;
      arop_pins_type pins;
   } arop_state_type;

   arop_state_type s_ff;
   arop_state_type nxt_s;

   // Two's complement is straight binary with the top bit flipped
   function automatic logic [WORD_W-1:0] arop_code(
      input logic [WORD_W-1:0] raw,
      input logic ob
   );
      arop_code = ob ? raw : {~raw[WORD_W-1], raw[WORD_W-2:0]};
   endfunction

   logic bus_en;
   logic start_fall;
   logic push;
   logic pop_ok;
   logic sclk_rise;
   logic sclk_fall;
   logic act_edge;
   logic qtr_done;

   always_comb begin
      bus_en = !s_ff.cs2 && !s_ff.rd2;
      start_fall = !s_ff.cnv2 && s_ff.cnv3;
      pop_ok = s_ff.fcnt != 2'h0;
      push = s_ff.busy && s_ff.conv_cnt == '0 && s_ff.fcnt != FIFO_DEPTH;
      sclk_rise = s_ff.sclk2 && !s_ff.sclk3;
      sclk_fall = !s_ff.sclk2 && s_ff.sclk3;
      act_edge = !s_ff.cs2 && (s_ff.cfg2.inv ? sclk_fall : sclk_rise);
      qtr_done = s_ff.qtr == '0;
   end

   always_comb begin
      nxt_s = s_ff;
      nxt_s.cfg1 = '{serial_parallel_select, clock_source_select,
         clock_invert_select, frame_polarity_select, output_coding_select};
      nxt_s.cfg2 = s_ff.cfg1;
      nxt_s.cnv1 = conversion_start_n;
      nxt_s.cnv2 = s_ff.cnv1;
      nxt_s.cnv3 = s_ff.cnv2;
      nxt_s.cs1 = cs_n;
      nxt_s.cs2 = s_ff.cs1;
      nxt_s.rd1 = rd_n;
      nxt_s.rd2 = s_ff.rd1;
      nxt_s.rst1 = reset_pin;
      nxt_s.rst2 = s_ff.rst1;
      nxt_s.sclk1 = sclk_pin_in;
      nxt_s.sclk2 = s_ff.sclk1;
      nxt_s.sclk3 = s_ff.sclk2;
      nxt_s.flag = 1'b0;

      // Conversion: hold the sample, count, then hand the word to the buffer
      if (start_fall && !s_ff.busy) begin
         nxt_s.busy = 1'b1;
         nxt_s.conv_cnt = CONV_LOAD;
         nxt_s.sample = sample_code;
      end else if (s_ff.busy && s_ff.conv_cnt != '0) begin
         nxt_s.conv_cnt = s_ff.conv_cnt - 1'b1;
      end
      // Full buffer stalls completion; busy stays high until a slot frees
      if (push) begin
         nxt_s.busy = 1'b0;
         nxt_s.mem[s_ff.wp] = arop_code(s_ff.sample, s_ff.cfg2.ob);
         nxt_s.wp = !s_ff.wp;
      end

      unique case (s_ff.state)
         AROP_IDLE: begin
            if (pop_ok && !s_ff.cfg2.ser) begin
               nxt_s.word = s_ff.mem[s_ff.rp];
               nxt_s.rp = !s_ff.rp;
            end else if (pop_ok && bus_en) begin
               nxt_s.word = s_ff.mem[s_ff.rp];
               nxt_s.shreg = s_ff.mem[s_ff.rp];
               nxt_s.rp = !s_ff.rp;
               nxt_s.bits = '0;
               nxt_s.qtr = QTR_LOAD;
               nxt_s.phase = PH_RISE;
               nxt_s.sclk_int = 1'b0;
               nxt_s.state = s_ff.cfg2.ext ? AROP_SLAVE : AROP_MASTER;
            end
         end
         AROP_MASTER: begin
            if (qtr_done) begin
               nxt_s.qtr = QTR_LOAD;
               nxt_s.phase = s_ff.phase + 2'h1;
               if (s_ff.phase == PH_RISE) begin
                  nxt_s.sclk_int = 1'b1;
               end
               if (s_ff.phase == PH_FALL) begin
                  nxt_s.sclk_int = 1'b0;
               end
               // Data moves a quarter period after the fall: stable on both
               if (s_ff.phase == PH_SHIFT) begin
                  nxt_s.shreg = {s_ff.shreg[WORD_W-2:0], 1'b0};
                  nxt_s.bits = s_ff.bits + 4'h1;
                  if (s_ff.bits == LAST_BIT) begin
                     nxt_s.state = AROP_IDLE;
                  end
               end
            end else begin
               nxt_s.qtr = s_ff.qtr - 1'b1;
            end
         end
         AROP_SLAVE: begin
            if (push) begin
               nxt_s.state = AROP_IDLE;
               nxt_s.flag = 1'b1;
            end else if (act_edge) begin
               nxt_s.shreg = {s_ff.shreg[WORD_W-2:0], 1'b0};
               nxt_s.bits = s_ff.bits + 4'h1;
               if (s_ff.bits == LAST_BIT) begin
                  nxt_s.state = AROP_IDLE;
               end
            end
         end
         default: nxt_s.state = AROP_IDLE;
      endcase

      nxt_s.fcnt = s_ff.fcnt + {1'b0, push} - {1'b0, nxt_s.rp != s_ff.rp};

      if (s_ff.rst2) begin
         nxt_s.busy = 1'b0;
         nxt_s.conv_cnt = '0;
         nxt_s.wp = 1'b0;
         nxt_s.rp = 1'b0;
         nxt_s.fcnt = '0;
         nxt_s.state = AROP_IDLE;
         nxt_s.sclk_int = 1'b0;
      end

      // Pin map, registered so every pin comes from a flip-flop
      nxt_s.pins = '0;
      if (!s_ff.cfg2.ser) begin
         nxt_s.pins.dout = s_ff.word;
         nxt_s.pins.oe = {WORD_W{bus_en}};
      end else begin
         nxt_s.pins.dout[PIN_SDO] = s_ff.shreg[WORD_W-1];
         nxt_s.pins.oe[PIN_SDO] = bus_en;
         nxt_s.pins.dout[PIN_SCLK] = s_ff.sclk_int ^ s_ff.cfg2.inv;
         nxt_s.pins.oe[PIN_SCLK] = bus_en && !s_ff.cfg2.ext;
         nxt_s.pins.dout[PIN_SYNC] =
            (s_ff.state == AROP_MASTER) ^ s_ff.cfg2.fpol;
         nxt_s.pins.oe[PIN_SYNC] = bus_en && !s_ff.cfg2.ext;
         nxt_s.pins.dout[PIN_FLAG] = s_ff.flag;
         nxt_s.pins.oe[PIN_FLAG] = bus_en && s_ff.cfg2.ext;
         nxt_s.pins.dout[WORD_W-1:UPPER_LO] = s_ff.word[WORD_W-1:UPPER_LO];
         nxt_s.pins.oe[WORD_W-1:UPPER_LO] = {(WORD_W-UPPER_LO){bus_en}};
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         s_ff <= '0;
         // Chip select and read syncs start idle, else the bus looks enabled
         s_ff.cs1 <= 1'b1;
         s_ff.cs2 <= 1'b1;
         s_ff.rd1 <= 1'b1;
         s_ff.rd2 <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   always_comb begin
      busy = s_ff.busy;
      data_pin_out = s_ff.pins.dout;
      data_pin_oe = s_ff.pins.oe;
   end

   default clocking arop_cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   a_busy_start: assert property (
      start_fall && !s_ff.busy && !s_ff.rst2 |=> s_ff.busy)
      else $error("busy did not rise on conversion start");
   a_busy_length: assert property (
      $rose(s_ff.busy) |-> s_ff.busy [*8])
      else $error("busy dropped too early");
   a_busy_latched: assert property (
      $fell(s_ff.busy) && !$past(s_ff.rst2) |-> s_ff.fcnt != 2'h0)
      else $error("busy fell without a latched result");
   a_reset_abort: assert property (
      s_ff.rst2 |=> !s_ff.busy && s_ff.state == AROP_IDLE)
      else $error("reset did not abort conversion");
   a_coding_msb: assert property (
      push && !s_ff.cfg2.ob && !s_ff.rst2 |=>
      s_ff.mem[$past(s_ff.wp)][WORD_W-1] != $past(s_ff.sample[WORD_W-1]))
      else $error("two's complement coding wrong");
   a_msb_shift: assert property (
      s_ff.state == AROP_MASTER && qtr_done && s_ff.phase == PH_SHIFT
      && !s_ff.rst2 |=> s_ff.shreg == {$past(s_ff.shreg[WORD_W-2:0]), 1'b0})
      else $error("shift order wrong");
   a_master_stable: assert property (
      $changed(s_ff.sclk_int) |-> $stable(s_ff.shreg))
      else $error("data moved on a serial clock edge");
   a_slave_hold: assert property (
      s_ff.state == AROP_SLAVE && !act_edge |=> $stable(s_ff.shreg))
      else $error("slave data moved without active edge");
   a_flag_pulse: assert property (
      s_ff.state == AROP_SLAVE && push && !s_ff.rst2 |=>
      s_ff.flag && s_ff.state == AROP_IDLE ##1 !s_ff.flag)
      else $error("incomplete read not flagged");
   a_bus_off: assert property (
      s_ff.cs2 || s_ff.rd2 |=> data_pin_oe == '0)
      else $error("pins driven while bus disabled");
   a_upper_out: assert property (
      bus_en |=> &data_pin_oe[WORD_W-1:UPPER_LO])
      else $error("upper bits not driven");
   a_sclk_dir: assert property (
      s_ff.cfg2.ser && s_ff.cfg2.ext |=> !data_pin_oe[PIN_SCLK]
      && !data_pin_oe[PIN_SYNC])
      else $error("clock or frame driven in slave mode");
   a_frame_level: assert property (
      s_ff.cfg2.ser && s_ff.state == AROP_MASTER |=>
      data_pin_out[PIN_SYNC] == !$past(s_ff.cfg2.fpol))
      else $error("frame marker level wrong");
   a_par_data: assert property (
      !s_ff.cfg2.ser |=> data_pin_out == $past(s_ff.word))
      else $error("parallel data wrong");
   a_par_enable: assert property (
      !s_ff.cfg2.ser && bus_en |=> data_pin_oe == '1)
      else $error("parallel bus not enabled");
   a_sdo_bit: assert property (
      s_ff.cfg2.ser |=> data_pin_out[PIN_SDO] == $past(s_ff.shreg[WORD_W-1]))
      else $error("serial output not the register head");
   a_slave_shift: assert property (
      s_ff.state == AROP_SLAVE && act_edge && !push && !s_ff.rst2 |=>
      s_ff.shreg == {$past(s_ff.shreg[WORD_W-2:0]), 1'b0})
      else $error("slave shift order wrong");
   a_ext_gated: assert property (
      s_ff.state == AROP_SLAVE && s_ff.cs2 |=> $stable(s_ff.bits))
      else $error("serial clock counted while deselected");
   a_flag_mode: assert property (
      s_ff.cfg2.ser && !s_ff.cfg2.ext |=> !data_pin_oe[PIN_FLAG])
      else $error("error flag driven outside slave mode");

   a_fifo_bound: assert property (
      s_ff.fcnt <= FIFO_DEPTH)
      else $error("result buffer overfilled");

   c_master_done: cover property (
      s_ff.state == AROP_MASTER ##1 s_ff.state == AROP_IDLE);
   c_slave_done: cover property (
      s_ff.state == AROP_SLAVE && act_edge && s_ff.bits == LAST_BIT);
   c_flag: cover property (s_ff.flag);
   c_full: cover property (s_ff.fcnt == FIFO_DEPTH && s_ff.busy);
   c_inv_slave: cover property (
      s_ff.state == AROP_SLAVE && act_edge && s_ff.cfg2.inv);

endmodule
`default_nettype wire

/* tb/arop_host.sv */
// Host model that clocks and collects serial results
`timescale 1ns/1ps
`default_nettype none
module arop_host
   import arop_pkg::*;
(
   input wire logic ext,
   input wire logic inv,
   input wire logic [WORD_W-1:0] pout,
   input wire logic [WORD_W-1:0] poe,
   output logic sclk,
   output logic [WORD_W-1:0] word
);
   initial sclk = 1'b0;
   initial word = '0;
   // A released data pin reads back inverted, so stale data cannot pass
   function automatic logic sdo();
      return poe[PIN_SDO] ? pout[PIN_SDO] : ~pout[PIN_SDO];
   endfunction
   // Master clock: bit is stable at the rising edge
   always @(posedge pout[PIN_SCLK]) begin
      if (!ext && poe[PIN_SCLK]) begin
         word = {word[WORD_W-2:0], sdo()};
      end
   end
   // Clock stands still at idle level outside a frame
   task automatic slave_read(input int nbits);
      sclk = inv;
      #32;
      for (int i = 0; i < nbits; i++) begin
         word = {word[WORD_W-2:0], sdo()};
         sclk = ~inv;
         #32;
         sclk = inv;
         #32;
      end
   endtask
endmodule
`default_nettype wire

/* tb/adc_result_output_port_tb_top.sv */
// Testbench for the converter result output port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin \
   fails++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module adc_result_output_port_tb_top
   import arop_pkg::*;
;
   logic mclk = 1'b0, rst_b = 1'b0, reset_pin = 1'b0, cnv_n = 1'b1;
   logic cs_n = 1'b1, rd_n = 1'b1, ser = 1'b0, ext = 1'b0, inv = 1'b0;
   logic fpol = 1'b0, ob = 1'b1, busy, sclk;
   logic [WORD_W-1:0] code = '0, dout, doe, word, w;
   logic [31:0] seed = 32'h27E6;
   logic [WORD_W-1:0] exp_q[$];
   int fails = 0, comparisons = 0, flags = 0, n;
   always #2.5 mclk = ~mclk;
   arop_port u_dut (.mclk(mclk), .rst_b(rst_b), .reset_pin(reset_pin),
      .conversion_start_n(cnv_n), .sample_code(code), .cs_n(cs_n),
      .rd_n(rd_n), .serial_parallel_select(ser),
      .clock_source_select(ext), .clock_invert_select(inv),
      .frame_polarity_select(fpol), .output_coding_select(ob),
      .sclk_pin_in(sclk), .busy(busy), .data_pin_out(dout),
      .data_pin_oe(doe));
   arop_host u_host (.ext(ext), .inv(inv), .pout(dout), .poe(doe),
      .sclk(sclk), .word(word));
   always @(posedge mclk) begin
      if ((doe[PIN_FLAG] & dout[PIN_FLAG]) === 1'b1) flags++;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic cyc(input int k);
      repeat (k) @(negedge mclk);
   endtask
   task automatic convert();
      w = WORD_W'(xs());
      code = w;
      exp_q.push_back(ob ? w : w ^ 16'h8000);
      cnv_n = 1'b0;
      n = 0;
      while (busy !== 1'b1 && n < 8) begin cyc(1); n++; end
      cnv_n = 1'b1;
      n = 0;
      while (busy === 1'b1 && n < 400) begin cyc(1); n++; end
      `CHK("busy_len", CONV_CYC, n)
   endtask
   // Serial reads run on the link clock; realign to the falling edge
   task automatic sread(input int k);
      u_host.slave_read(k);
      cyc(1);
   endtask
   task automatic bus(input logic en);
      cs_n = ~en;
      rd_n = ~en;
      cyc(8);
   endtask
   task automatic summarize();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      #100000;
      fails++;
      summarize();
   end
   initial begin
      cyc(6);
      rst_b = 1'b1;
      cyc(4);
      for (int i = 0; i < 2; i++) begin
         ob = i[0];
         bus(1'b0);
         convert();
         cyc(4);
         `CHK("oe_off", 16'h0000, doe)
         bus(1'b1);
         `CHK("par_word", exp_q.pop_front(), dout)
         `CHK("par_oe", 16'hFFFF, doe)
      end
      $display("parallel test done");
      ser = 1'b1;
      for (int i = 0; i < 2; i++) begin
         fpol = i[0];
         inv = i[0];
         bus(1'b0);
         convert();
         bus(1'b1);
         `CHK("frame_on", ~fpol, dout[PIN_SYNC])
         `CHK("oe_flag", 1'b0, doe[PIN_FLAG])
         cyc(16 * 8);
         `CHK("frame_off", fpol, dout[PIN_SYNC])
         `CHK("master_word", exp_q.pop_front(), word)
      end
      $display("master test done");
      ext = 1'b1;
      for (int i = 0; i < 2; i++) begin
         inv = i[0];
         bus(1'b0);
         convert();
         bus(1'b1);
         cs_n = 1'b1;
         sread(3);
         cs_n = 1'b0;
         cyc(4);
         `CHK("oe_slave", 2'b10, doe[PIN_FLAG:PIN_SCLK+1])
         sread(16);
         `CHK("slave_word", exp_q.pop_front(), word)
      end
      $display("slave test done");
      convert();
      sread(5);
      convert();
      cyc(4);
      `CHK("flag_pulses", 1, flags)
      w = exp_q.pop_front();
      sread(16);
      `CHK("after_abort", exp_q.pop_front(), word)
      $display("abort test done");
      cnv_n = 1'b0;
      cyc(20);
      reset_pin = 1'b1;
      cyc(5);
      reset_pin = 1'b0;
      cnv_n = 1'b1;
      cyc(2);
      `CHK("busy_reset", 1'b0, busy)
      $display("reset test done");
      summarize();
   end
endmodule
`default_nettype wire
